// >>> design/pio_map.svh
// Register offsets, field positions and reset values of the parallel port block.
// Included by the package users; definitions only.
`ifndef PIO_MAP_SVH
`define PIO_MAP_SVH
`define PIO_PORT_A_DATA_IDX 3'h0
`define PIO_PORT_B_DATA_IDX 3'h1
`define PIO_PORT_C_DATA_IDX 3'h2
`define PIO_PORT_D_DATA_IDX 3'h3
`define PIO_PORT_A_DIR_IDX 3'h4
`define PIO_PORT_B_DIR_IDX 3'h5
`define PIO_PORT_C_DIR_IDX 3'h6
`define PIO_PORT_D_DIR_IDX 3'h7
`define PIO_SHARE_CTRL_IDX 4'h8
`define PIO_REG_COUNT 9
`define PIO_B_MASK 8'hE0
`define PIO_D_DIR_MASK 8'h20
`define PIO_D_IN_BIT 7
`define PIO_D_BIDIR_BIT 5
`define PIO_SER_EN_BIT 0
`define PIO_CONV_ON_BIT 1
`define PIO_DIR_RESET 8'h00
`define PIO_CONV_MASK 8'hF8
`endif

// >>> design/pio_pkg.sv
// Types shared by the parallel port block.
// Assumes pio_map.svh supplies the numeric constants.
`default_nettype none
package pio_pkg;
   typedef struct packed {
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] c;
      logic [7:0] d;
   } pio_ports_t;
   typedef struct packed {
      logic sdo;
      logic sck_out;
      logic sck_drive;
   } pio_serial_t;
endpackage : pio_pkg
`default_nettype wire

// >>> design/pio_top.sv
// Four parallel ports with APB register access and pin sharing.
// Assumes one 100 MHz clock, pin inputs synchronous to it, APB master outside.
//
// What this block does
// - Reset clears directions; data latches keep contents
// - Direction bit one drives latch, zero floats
// - Input-mode write stores latch; read returns pin
// - Output-mode read returns latch, not pin
// - Direction registers readable, writable, zero after reset
// - Port A eight bits at 0 and 4
// - Port B bits 5-7 at 1 and 5
// - Port C eight bits at 2 and 6
// - Port D bit5 bidir, bit7 input, 3/7
// - Port D bit 7 always readable
// - Serial enable gives port B pins to serial
// - Port B registers stay accessible while serial
`include "pio_map.svh"
`timescale 1ns/1ns
`default_nettype none
module pio_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire pio_pkg::pio_ports_t pin_in,
   output pio_pkg::pio_ports_t pin_out,
   output pio_pkg::pio_ports_t pin_oe_n,
   input wire pio_pkg::pio_serial_t serial_in,
   output logic serial_unit_enable,
   output logic converter_power_on
);
   import pio_pkg::*;

   pio_ports_t data_r;
   pio_ports_t dir_r;
   logic [7:0] share_r;
   pio_ports_t pin_out_nxt;
   pio_ports_t pin_oe_n_nxt;
   logic [31:0] rdata_nxt;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic [3:0] word_idx;

   // Single-wait-state slave: answer in the access phase of every transfer
   assign word_idx = paddr[5:2];
   assign addr_ok = (paddr[31:6] == 26'h0) && (paddr[1:0] == 2'h0)
      && (word_idx < 4'(`PIO_REG_COUNT));
   assign wr_en = psel && penable && pwrite && addr_ok && pstrb[0] && !pready;
   assign rd_en = psel && penable && !pwrite && !pready;

   // Data latches have no reset: contents undefined until software writes
   // Index 8 aliases index 0 in the low bits, so data writes need the upper bits clear
   always_ff @(posedge pclk) begin
      if (wr_en && !word_idx[3] && !word_idx[2]) begin
         unique case (word_idx[2:0])
            `PIO_PORT_A_DATA_IDX: data_r.a <= pwdata[7:0];
            `PIO_PORT_B_DATA_IDX: data_r.b <= pwdata[7:0] & `PIO_B_MASK;
            `PIO_PORT_C_DATA_IDX: data_r.c <= pwdata[7:0];
            `PIO_PORT_D_DATA_IDX: data_r.d <= pwdata[7:0] & `PIO_D_DIR_MASK;
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_r <= {4{`PIO_DIR_RESET}};
      end else if (wr_en && word_idx[3] == 1'b0 && word_idx[2]) begin
         unique case (word_idx[2:0])
            `PIO_PORT_A_DIR_IDX: dir_r.a <= pwdata[7:0];
            `PIO_PORT_B_DIR_IDX: dir_r.b <= pwdata[7:0] & `PIO_B_MASK;
            `PIO_PORT_C_DIR_IDX: dir_r.c <= pwdata[7:0];
            `PIO_PORT_D_DIR_IDX: dir_r.d <= pwdata[7:0] & `PIO_D_DIR_MASK;
            default: ;
         endcase
      end
   end

   // Sharing control: serial enable and converter power
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         share_r <= 8'h00;
      end else if (wr_en && word_idx == `PIO_SHARE_CTRL_IDX) begin
         share_r <= pwdata[7:0] & 8'h03;
      end
   end

   // Read mux: pin level for inputs, latch for outputs
   function automatic logic [7:0] port_read(input logic [7:0] lat, input logic [7:0] dir,
                                            input logic [7:0] pin);
      port_read = (lat & dir) | (pin & ~dir);
   endfunction : port_read

   always_comb begin
      rdata_nxt = 32'h0;
      if (addr_ok) begin
         unique case (word_idx)
            4'h0: rdata_nxt[7:0] = port_read(data_r.a, dir_r.a, pin_in.a);
            4'h1: rdata_nxt[7:0] = port_read(data_r.b, dir_r.b, pin_in.b) & `PIO_B_MASK;
            4'h2: rdata_nxt[7:0] = port_read(data_r.c, dir_r.c, pin_in.c);
            4'h3: begin
               rdata_nxt[7:0] = port_read(data_r.d, dir_r.d, pin_in.d) & `PIO_D_DIR_MASK;
               rdata_nxt[`PIO_D_IN_BIT] = pin_in.d[`PIO_D_IN_BIT];
            end
            4'h4: rdata_nxt[7:0] = dir_r.a;
            4'h5: rdata_nxt[7:0] = dir_r.b;
            4'h6: rdata_nxt[7:0] = dir_r.c;
            4'h7: rdata_nxt[7:0] = dir_r.d;
            4'h8: rdata_nxt[7:0] = share_r;
            default: rdata_nxt = 32'h0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !addr_ok;
         prdata <= rd_en ? rdata_nxt : 32'h0;
      end
   end

   // Pin drive; serial unit overrides port B when enabled
   always_comb begin
      pin_out_nxt = data_r;
      pin_oe_n_nxt = ~dir_r;
      pin_oe_n_nxt.d[`PIO_D_IN_BIT] = 1'b1;
      if (share_r[`PIO_SER_EN_BIT]) begin
         pin_out_nxt.b[5] = serial_in.sdo;
         pin_oe_n_nxt.b[5] = 1'b0;
         pin_oe_n_nxt.b[6] = 1'b1;
         pin_out_nxt.b[7] = serial_in.sck_out;
         pin_oe_n_nxt.b[7] = !serial_in.sck_drive;
      end
   end

   // Outputs registered; one cycle behind the latch and direction
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_out <= '0;
         pin_oe_n <= '1;
         serial_unit_enable <= 1'b0;
         converter_power_on <= 1'b0;
      end else begin
         pin_out <= pin_out_nxt;
         pin_oe_n <= pin_oe_n_nxt;
         serial_unit_enable <= share_r[`PIO_SER_EN_BIT];
         converter_power_on <= share_r[`PIO_CONV_ON_BIT];
      end
   end

   a_dir_reset_inputs: assert property (@(posedge pclk)
      $rose(presetn) |-> pin_oe_n == '1)
      else $error("pins not inputs after reset");
   a_oe_follows_dir: assert property (@(posedge pclk) disable iff (!presetn)
      !share_r[0] |=> pin_oe_n.a == ~$past(dir_r.a))
      else $error("port a enable not from direction");
   a_out_read_latch: assert property (@(posedge pclk) disable iff (!presetn)
      rd_en && word_idx == 4'h2 && dir_r.c == 8'hFF |=> prdata[7:0] == $past(data_r.c))
      else $error("output read not latch");
   a_in_read_pin: assert property (@(posedge pclk) disable iff (!presetn)
      rd_en && word_idx == 4'h0 && dir_r.a == 8'h00 |=> prdata[7:0] == $past(pin_in.a))
      else $error("input read not pin");
   a_dir_readback: assert property (@(posedge pclk) disable iff (!presetn)
      rd_en && word_idx == 4'h4 |=> prdata[7:0] == $past(dir_r.a))
      else $error("direction readback wrong");
   a_d_in_bit: assert property (@(posedge pclk) disable iff (!presetn)
      rd_en && word_idx == 4'h3 |=> prdata[7] == $past(pin_in.d[7]))
      else $error("port d bit 7 not pin");
   a_serial_owns_b: assert property (@(posedge pclk) disable iff (!presetn)
      share_r[0] |=> !pin_oe_n.b[5] && pin_oe_n.b[6])
      else $error("serial did not take port b");
   a_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
      rd_en && (word_idx == 4'h5 || word_idx == 4'h7) |=> prdata[4:0] == 5'h0)
      else $error("unimplemented bits not zero");
   a_d7_never_out: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 pin_oe_n.d[7] && pin_oe_n.d[6] && pin_oe_n.d[0])
      else $error("port d unused pin driven");

   a_share_reset_off: assert property (@(posedge pclk)
      $rose(presetn) |-> !serial_unit_enable && !converter_power_on)
      else $error("sharing enables not clear after reset");

   a_dir_zero_reset: assert property (@(posedge pclk)
      $rose(presetn) |-> dir_r == '0)
      else $error("direction not zero after reset");

   a_ready_reset: assert property (@(posedge pclk)
      $rose(presetn) |-> !pready && !pslverr)
      else $error("bus answer active after reset");

   a_oe_dir_b: assert property (@(posedge pclk) disable iff (!presetn)
      !share_r[0] |=> pin_oe_n.b == ~$past(dir_r.b))
      else $error("port b enable not from direction");

   a_oe_dir_c: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> pin_oe_n.c == ~$past(dir_r.c))
      else $error("port c enable not from direction");

   a_oe_dir_d5: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> pin_oe_n.d[5] == !$past(dir_r.d[5]))
      else $error("port d bit 5 enable not from direction");

   a_out_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
      dir_r.a == 8'hFF |=> pin_out.a == $past(data_r.a))
      else $error("port a output not latch");

   a_out_drive_c: assert property (@(posedge pclk) disable iff (!presetn)
      dir_r.c == 8'hFF |=> pin_out.c == $past(data_r.c))
      else $error("port c output not latch");

   a_b_out_read: assert property (@(posedge pclk) disable iff (!presetn)
      rd_en && word_idx == 4'h1 && dir_r.b == 8'hE0 |=> prdata[7:0] == $past(data_r.b))
      else $error("port b output read not latch");

   a_dir_readback_b: assert property (@(posedge pclk) disable iff (!presetn)
      rd_en && word_idx == 4'h5 |=> prdata[7:0] == $past(dir_r.b))
      else $error("port b direction readback wrong");

   a_dir_readback_c: assert property (@(posedge pclk) disable iff (!presetn)
      rd_en && word_idx == 4'h6 |=> prdata[7:0] == $past(dir_r.c))
      else $error("port c direction readback wrong");

   a_dir_readback_d: assert property (@(posedge pclk) disable iff (!presetn)
      rd_en && word_idx == 4'h7 |=> prdata[7:0] == $past(dir_r.d))
      else $error("port d direction readback wrong");

   a_read_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
      pready |-> prdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");

   a_idle_rdata_zero: assert property (@(posedge pclk) disable iff (!presetn)
      !pready |-> prdata == 32'h0)
      else $error("read data not zero outside answer");

   a_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("ready longer than one cycle");

   a_ready_after_access: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !pready |=> pready)
      else $error("no ready after access");

   a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("error without ready");

   a_map_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && word_idx == 4'h4 |=> dir_r.a == $past(pwdata[7:0]))
      else $error("port a direction write lost");

   a_map_data_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && word_idx == 4'h0 |=> data_r.a == $past(pwdata[7:0]))
      else $error("port a data write lost");

   a_b_data_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && word_idx == 4'h1 |=> data_r.b == ($past(pwdata[7:0]) & `PIO_B_MASK))
      else $error("port b data write wrong");

   a_b_dir_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && word_idx == 4'h5 |=> dir_r.b == ($past(pwdata[7:0]) & `PIO_B_MASK))
      else $error("port b direction write wrong");

   a_c_dir_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && word_idx == 4'h6 |=> dir_r.c == $past(pwdata[7:0]))
      else $error("port c direction write wrong");

   a_c_data_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && word_idx == 4'h2 |=> data_r.c == $past(pwdata[7:0]))
      else $error("port c data write wrong");

   a_d_dir_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && word_idx == 4'h7 |=> dir_r.d == ($past(pwdata[7:0]) & `PIO_D_DIR_MASK))
      else $error("port d direction write wrong");

   a_d_data_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && word_idx == 4'h3 |=> data_r.d == ($past(pwdata[7:0]) & `PIO_D_DIR_MASK))
      else $error("port d data write wrong");

   a_serial_data_pin: assert property (@(posedge pclk) disable iff (!presetn)
      share_r[0] |=> pin_out.b[5] == $past(serial_in.sdo))
      else $error("serial data not on pin");

   a_serial_clk_pin: assert property (@(posedge pclk) disable iff (!presetn)
      share_r[0] |=> pin_oe_n.b[7] == !$past(serial_in.sck_drive))
      else $error("serial clock drive wrong");

   a_serial_flag_out: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> serial_unit_enable == $past(share_r[0]))
      else $error("serial enable output wrong");

   a_conv_flag_out: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> converter_power_on == $past(share_r[1]))
      else $error("converter output wrong");

   a_b_regs_serial: assert property (@(posedge pclk) disable iff (!presetn)
      share_r[0] && wr_en && word_idx == 4'h5 |=> dir_r.b == ($past(pwdata[7:0]) & 8'hE0))
      else $error("port b direction locked by serial");

   a_b_dir_unused: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |-> (dir_r.b & 8'h1F) == 8'h00)
      else $error("port b unused direction bits set");

   a_d_dir_unused: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |-> (dir_r.d & 8'hDF) == 8'h00)
      else $error("port d unused direction bits set");

   a_b_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
      rd_en && word_idx == 4'h1 |=> prdata[4:0] == 5'h00)
      else $error("port b unused data bits not zero");

   a_d_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
      rd_en && word_idx == 4'h3 |=> prdata[6] == 1'b0 && prdata[4:0] == 5'h00)
      else $error("port d unused data bits not zero");

   a_bad_addr_err: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !pready && !addr_ok |=> pslverr)
      else $error("unmapped access without error");

   a_share_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && word_idx == 4'h8 |=> share_r == ($past(pwdata[7:0]) & 8'h03))
      else $error("sharing control write wrong");

   a_share_keeps_dir: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && word_idx == 4'h8 |=> $stable(dir_r))
      else $error("sharing write hit direction");

   a_in_read_pin_c: assert property (@(posedge pclk) disable iff (!presetn)
      rd_en && word_idx == 4'h2 && dir_r.c == 8'h00 |=> prdata[7:0] == $past(pin_in.c))
      else $error("port c input read not pin");

   a_out_read_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
      rd_en && word_idx == 4'h0 && dir_r.a == 8'hFF |=> prdata[7:0] == $past(data_r.a))
      else $error("port a output read not latch");
endmodule : pio_top
`default_nettype wire

// >>> tb/pio_pins_model.sv
// External circuit hanging on the four ports.
// Assumes the bench picks the level seen on every pin it does not drive.
`timescale 1ns/1ns
`default_nettype none
module pio_pins_model (
   input wire pio_pkg::pio_ports_t pin_out,
   input wire pio_pkg::pio_ports_t pin_oe_n,
   input wire pio_pkg::pio_ports_t ext,
   input wire logic load,
   output var pio_pkg::pio_ports_t pin_in
);
   import pio_pkg::*;
   // Heavy load overrides a driven pin, so latch and pin level differ
   assign pin_in = load ? ext : (pin_out & ~pin_oe_n) | (ext & pin_oe_n);
endmodule : pio_pins_model
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the parallel port block.
// Assumes pio_top with APB registers and the pin model beside it.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; $display("BAD %0t got %h want %h", $time, a, b); end end
module tb;
   import pio_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, load = 0, err;
   logic pready, pslverr, serial_unit_enable, converter_power_on;
   logic [31:0] paddr = 0, pwdata = 0, prdata, rnd = 65965, rd;
   logic [7:0] e;
   pio_ports_t pin_in, pin_out, pin_oe_n, ext = '0;
   pio_serial_t serial_in = '0;
   int bad_count = 0, n_checks = 0, p;
   int lat[4], dir[4];
   int dm[4] = '{'hFF, 'hE0, 'hFF, 'h20};
   int im[4] = '{'hFF, 'hE0, 'hFF, 'hA0};
   always #5 pclk = ~pclk;
   pio_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
      .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe_n, .serial_in,
      .serial_unit_enable, .converter_power_on);
   pio_pins_model i_pins (.pin_out, .pin_oe_n, .ext, .load, .pin_in);
   function automatic logic [31:0] lfsr(logic [31:0] x);
      return (x >> 1) ^ (x[0] ? 32'h80200003 : 32'h00000000);
   endfunction : lfsr
   // Ends one edge after release, so psel never changes twice in a step
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk iff pready);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : print_verdict
   initial begin
      #300000;
      bad_count++;
      print_verdict();
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      `CHK(pin_oe_n, 32'hFFFFFFFF)
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 16 + 4 * i, 0);
         `CHK(rd, 32'h00000000)
      end
      repeat (60) begin
         p = rnd % 4;
         rnd = lfsr(rnd);
         lat[p] = rnd[7:0] & im[p];
         apb(1'b1, p * 4, rnd[7:0]);
         rnd = lfsr(rnd);
         dir[p] = rnd[15:8] & dm[p];
         apb(1'b1, 16 + p * 4, rnd[15:8]);
         ext <= rnd;
         load <= rnd[20];
         e = rnd[31 - 8 * p -: 8];
         apb(1'b0, 16 + p * 4, 0);
         `CHK(rd, 32'(dir[p]))
         apb(1'b0, p * 4, 0);
         `CHK(rd[7:0], 8'(((dir[p] & lat[p]) | (~dir[p] & e)) & im[p]))
         `CHK(pin_oe_n[31 - 8 * p -: 8] | ~8'(dm[p]), ~8'(dir[p]))
         `CHK(pin_out[31 - 8 * p -: 8] & 8'(dir[p]), 8'(lat[p] & dir[p]))
      end
      // Serial owns port B: sdo high, clock driven low
      serial_in <= 3'b101;
      // Converter on: bench leaves port C alone from here on
      apb(1'b1, 32'h20, 3);
      `CHK(converter_power_on, 1'b1)
      `CHK({serial_unit_enable, pin_out.b[5], pin_oe_n.b[5], pin_out.b[7], pin_oe_n.b[7]}, 5'h18)
      apb(1'b1, 32'h14, 32'hE0);
      apb(1'b0, 32'h14, 0);
      `CHK(rd[7:0], 8'hE0)
      apb(1'b0, 32'h24, 0);
      `CHK({err, rd}, {1'b1, 32'h0})
      apb(1'b1, 0, 32'h5A);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      `CHK(pin_oe_n, 32'hFFFFFFFF)
      apb(1'b1, 16, 32'hFF);
      apb(1'b0, 0, 0);
      `CHK(rd[7:0], 8'h5A)
      print_verdict();
   end
endmodule : tb
`default_nettype wire
